// ===== cvr_ref_ctrl.sv
`include "cvr_regs.svh"

module cvr_ref_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input cvr_pkg::cvr_bus_req_t bus_req,
    output logic [`CVR_DATA_W-1:0] rdata,
    input wire logic [`CVR_NUM_CMP-1:0] noninv_input_select,
    input wire logic [`CVR_NUM_CMP-1:0][1:0] inv_input_channel,
    output cvr_pkg::cvr_ctrl_t ref_ctrl,
    output logic ladder_range,
    output cvr_pkg::cvr_noninv_route_t [`CVR_NUM_CMP-1:0] noninv_route,
    output cvr_pkg::cvr_inv_route_t [`CVR_NUM_CMP-1:0] inv_route
);
    import cvr_pkg::*;

    // ------------------------------------------------------------
    // Control register.
    // ------------------------------------------------------------
    cvr_ctrl_t next_ref_ctrl;
    logic next_ladder_range;
    logic wr_ctrl;

    assign wr_ctrl = bus_req.wr && (bus_req.addr == `CVR_OFS_CONTROL);

    always_comb begin
        next_ref_ctrl = ref_ctrl;
        if (wr_ctrl) begin
            next_ref_ctrl = bus_req.wdata[`CVR_BIT_EXT_REF:0];
        end
        next_ladder_range = next_ref_ctrl.ladder_level_code[`CVR_BIT_RANGE];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_ctrl <= `CVR_CONTROL_RESET;
            ladder_range <= 1'b0;
        end else begin
            ref_ctrl <= next_ref_ctrl;
            ladder_range <= next_ladder_range;
        end
    end

    // ------------------------------------------------------------
    // Comparator input routing.
    // ------------------------------------------------------------
    cvr_noninv_route_t [`CVR_NUM_CMP-1:0] next_noninv_route;
    cvr_inv_route_t [`CVR_NUM_CMP-1:0] next_inv_route;

    for (genvar i = 0; i < `CVR_NUM_CMP; i++) begin : g_cmp
        always_comb begin
            if (!noninv_input_select[i]) begin
                next_noninv_route[i] = CVR_NI_PIN_A;
            end else if (next_ref_ctrl.external_ref_select) begin
                next_noninv_route[i] = CVR_NI_EXT_REF;
            end else begin
                next_noninv_route[i] = CVR_NI_LADDER;
            end
            case (inv_input_channel[i])
                `CVR_CH_PIN_B: next_inv_route[i] = CVR_INV_PIN_B;
                `CVR_CH_PIN_C: next_inv_route[i] = CVR_INV_PIN_C;
                `CVR_CH_PIN_D: next_inv_route[i] = CVR_INV_PIN_D;
                default: begin
                    case (next_ref_ctrl.bandgap_source_select)
                        `CVR_BG_BANDGAP: next_inv_route[i] = CVR_INV_BANDGAP;
                        `CVR_BG_EXT_REF: next_inv_route[i] = CVR_INV_EXT_REF;
                        default: next_inv_route[i] = CVR_INV_OPEN;
                    endcase
                end
            endcase
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                noninv_route[i] <= CVR_NI_PIN_A;
                inv_route[i] <= CVR_INV_PIN_B;
            end else begin
                noninv_route[i] <= next_noninv_route[i];
                inv_route[i] <= next_inv_route[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Read port.
    // ------------------------------------------------------------
    logic [`CVR_DATA_W-1:0] next_rdata;
    logic [`CVR_DATA_W-1:0] status_word;

    always_comb begin
        status_word = '0;
        for (int k = 0; k < `CVR_NUM_CMP; k++) begin
            status_word[k] = (noninv_route[k] == CVR_NI_LADDER);
            status_word[k + 4] = (inv_route[k] == CVR_INV_OPEN);
        end
        status_word[8] = ladder_range;
        next_rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `CVR_OFS_CONTROL: next_rdata = {`CVR_CONTROL_PAD, ref_ctrl};
                `CVR_OFS_STATUS: next_rdata = status_word;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    property p_pad_zero;
        @(posedge ref_clk) disable iff (rst)
        bus_req.rd |=> (rdata[15:11] == 5'h00);
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("Upper control bits not zero.");

    property p_ext_ref;
        @(posedge ref_clk) disable iff (rst)
        (noninv_input_select[0] && !wr_ctrl && ref_ctrl.external_ref_select)
        |=> (noninv_route[0] == CVR_NI_EXT_REF);
    endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("External reference not routed.");

    property p_bg_route;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[0] == 2'h3 && !wr_ctrl && ref_ctrl.bandgap_source_select == 2'h0)
        |=> (inv_route[0] == CVR_INV_BANDGAP);
    endproperty
    a_bg_route: assert property (p_bg_route) else $error("Band gap not routed.");

    property p_power;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> (ref_ctrl.ladder_power_on == $past(bus_req.wdata[7]));
    endproperty
    a_power: assert property (p_power) else $error("Power bit not written.");

    property p_pin_out;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> (ref_ctrl.ladder_pin_output_on == $past(bus_req.wdata[6]));
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("Pin output bit not written.");

    property p_supply_level;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> ({ref_ctrl.ladder_supply_select, ref_ctrl.ladder_level_code}
                     == $past(bus_req.wdata[5:0]));
    endproperty
    a_supply_level: assert property (p_supply_level) else $error("Level not written.");

    property p_range;
        @(posedge ref_clk) disable iff (rst)
        ##1 (ladder_range == ref_ctrl.ladder_level_code[4]);
    endproperty
    a_range: assert property (p_range) else $error("Range flag mismatch.");

    property p_pin_a;
        @(posedge ref_clk) disable iff (rst)
        !noninv_input_select[1] |=> (noninv_route[1] == CVR_NI_PIN_A);
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("Pin A not routed.");

    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        !wr_ctrl [*2] |-> $stable(ref_ctrl);
    endproperty
    a_hold: assert property (p_hold) else $error("Control changed without write.");

    property p_ladder_0;
        @(posedge ref_clk) disable iff (rst)
        (noninv_input_select[0] && !wr_ctrl && !ref_ctrl.external_ref_select)
        |=> (noninv_route[0] == CVR_NI_LADDER);
    endproperty
    a_ladder_0: assert property (p_ladder_0) else $error("Ladder not routed.");

    property p_ext_ref_2;
        @(posedge ref_clk) disable iff (rst)
        (noninv_input_select[2] && !wr_ctrl && ref_ctrl.external_ref_select)
        |=> (noninv_route[2] == CVR_NI_EXT_REF);
    endproperty
    a_ext_ref_2: assert property (p_ext_ref_2) else $error("External reference not routed.");

    property p_ladder_2;
        @(posedge ref_clk) disable iff (rst)
        (noninv_input_select[2] && !wr_ctrl && !ref_ctrl.external_ref_select)
        |=> (noninv_route[2] == CVR_NI_LADDER);
    endproperty
    a_ladder_2: assert property (p_ladder_2) else $error("Ladder not routed.");

    property p_pin_a_0;
        @(posedge ref_clk) disable iff (rst)
        !noninv_input_select[0] |=> (noninv_route[0] == CVR_NI_PIN_A);
    endproperty
    a_pin_a_0: assert property (p_pin_a_0) else $error("Pin A not routed.");

    property p_pin_a_2;
        @(posedge ref_clk) disable iff (rst)
        !noninv_input_select[2] |=> (noninv_route[2] == CVR_NI_PIN_A);
    endproperty
    a_pin_a_2: assert property (p_pin_a_2) else $error("Pin A not routed.");

    property p_internal_0;
        @(posedge ref_clk) disable iff (rst)
        noninv_input_select[0] |=> (noninv_route[0] != CVR_NI_PIN_A);
    endproperty
    a_internal_0: assert property (p_internal_0) else $error("Internal reference not used.");

    property p_internal_2;
        @(posedge ref_clk) disable iff (rst)
        noninv_input_select[2] |=> (noninv_route[2] != CVR_NI_PIN_A);
    endproperty
    a_internal_2: assert property (p_internal_2) else $error("Internal reference not used.");

    property p_inv_pin_b;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[1] == 2'h0) |=> (inv_route[1] == CVR_INV_PIN_B);
    endproperty
    a_inv_pin_b: assert property (p_inv_pin_b) else $error("Pin B not routed.");

    property p_inv_pin_c;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[1] == 2'h1) |=> (inv_route[1] == CVR_INV_PIN_C);
    endproperty
    a_inv_pin_c: assert property (p_inv_pin_c) else $error("Pin C not routed.");

    property p_inv_pin_d;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[2] == 2'h2) |=> (inv_route[2] == CVR_INV_PIN_D);
    endproperty
    a_inv_pin_d: assert property (p_inv_pin_d) else $error("Pin D not routed.");

    property p_inv_ext;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[0] == 2'h3 && !wr_ctrl && ref_ctrl.bandgap_source_select == 2'h3)
        |=> (inv_route[0] == CVR_INV_EXT_REF);
    endproperty
    a_inv_ext: assert property (p_inv_ext) else $error("External reference not offered.");

    property p_inv_open;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[0] == 2'h3 && !wr_ctrl && ref_ctrl.bandgap_source_select[1] != ref_ctrl.bandgap_source_select[0])
        |=> (inv_route[0] == CVR_INV_OPEN);
    endproperty
    a_inv_open: assert property (p_inv_open) else $error("Reserved code not left open.");

    property p_bg_route_2;
        @(posedge ref_clk) disable iff (rst)
        (inv_input_channel[2] == 2'h3 && !wr_ctrl && ref_ctrl.bandgap_source_select == 2'h0)
        |=> (inv_route[2] == CVR_INV_BANDGAP);
    endproperty
    a_bg_route_2: assert property (p_bg_route_2) else $error("Band gap not routed.");

    property p_ctrl_write;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> (ref_ctrl == $past(bus_req.wdata[10:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("Control word not written.");

    property p_rd_ctrl;
        @(posedge ref_clk) disable iff (rst)
        (bus_req.rd && bus_req.addr == `CVR_OFS_CONTROL)
        |=> (rdata == {5'h00, $past(ref_ctrl)});
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("Control read wrong.");

    property p_rd_idle;
        @(posedge ref_clk) disable iff (rst)
        !bus_req.rd |=> (rdata == 16'h0000);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("Read data not cleared.");

    property p_reset_clear;
        @(posedge ref_clk)
        $past(rst) |-> (ref_ctrl == 11'h000 && rdata == 16'h0000
                        && noninv_route[0] == CVR_NI_PIN_A && inv_route[0] == CVR_INV_PIN_B);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Reset state wrong.");

    property p_status_range;
        @(posedge ref_clk) disable iff (rst)
        (bus_req.rd && bus_req.addr == `CVR_OFS_STATUS)
        |=> (rdata[8] == $past(ladder_range));
    endproperty
    a_status_range: assert property (p_status_range) else $error("Status range wrong.");

    property p_range_hi;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && bus_req.wdata[4]) |=> ladder_range;
    endproperty
    a_range_hi: assert property (p_range_hi) else $error("Upper range not flagged.");

    property p_range_lo;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !bus_req.wdata[4]) |=> !ladder_range;
    endproperty
    a_range_lo: assert property (p_range_lo) else $error("Lower range not flagged.");

    property p_ext_bit;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> (ref_ctrl.external_ref_select == $past(bus_req.wdata[10]));
    endproperty
    a_ext_bit: assert property (p_ext_bit) else $error("Reference select not written.");

    property p_bg_bits;
        @(posedge ref_clk) disable iff (rst)
        wr_ctrl |=> (ref_ctrl.bandgap_source_select == $past(bus_req.wdata[9:8]));
    endproperty
    a_bg_bits: assert property (p_bg_bits) else $error("Band gap select not written.");

endmodule : cvr_ref_ctrl

// ===== cvr_regs.svh
// Functional notes
// - Control register is 16 bits; bits 15 to 11 store nothing and read zero.
// - Bit 10 picks external positive reference or ladder for comparator reference.
// - Bits 9:8 pick inverting source: 00 band gap, 11 external, others reserved.
// - Bit 7 powers the reference ladder on when one, down when zero.
// - Bit 6 connects the generated reference to its output pin when set.
// - Bit 5 picks ladder span: external references when set, analog rails when clear.
// - Bits 4:0 hold level code 0 to 31; output is low rail plus code/32 span.
// - Two output ranges of 16 levels each, flagged by level code bit 4, with the same step size.
// - Noninverting select set routes internal reference; clear routes first external pin.
// - Channel select 11 routes inverting input to the band-gap source selection.
`ifndef CVR_REGS_SVH
`define CVR_REGS_SVH

`define CVR_ADDR_W 16
`define CVR_DATA_W 16
`define CVR_NUM_CMP 3
`define CVR_OFS_CONTROL 16'h0000
`define CVR_OFS_STATUS 16'h0004
`define CVR_CONTROL_RESET 11'h000
`define CVR_CONTROL_PAD 5'h00
`define CVR_BIT_EXT_REF 10
`define CVR_BIT_BG_HI 9
`define CVR_BIT_BG_LO 8
`define CVR_BIT_POWER 7
`define CVR_BIT_PIN_OUT 6
`define CVR_BIT_SUPPLY 5
`define CVR_BIT_LEVEL_HI 4
`define CVR_BIT_LEVEL_LO 0
`define CVR_BIT_RANGE 4
`define CVR_BG_BANDGAP 2'h0
`define CVR_BG_EXT_REF 2'h3
`define CVR_CH_PIN_B 2'h0
`define CVR_CH_PIN_C 2'h1
`define CVR_CH_PIN_D 2'h2
`define CVR_CH_INTERNAL 2'h3

`endif

// ===== cvr_pkg.sv
`include "cvr_regs.svh"

package cvr_pkg;

    typedef struct packed {
        logic external_ref_select;
        logic [1:0] bandgap_source_select;
        logic ladder_power_on;
        logic ladder_pin_output_on;
        logic ladder_supply_select;
        logic [4:0] ladder_level_code;
    } cvr_ctrl_t;

    typedef enum logic [1:0] {
        CVR_NI_PIN_A,
        CVR_NI_LADDER,
        CVR_NI_EXT_REF
    } cvr_noninv_route_t;

    typedef enum logic [2:0] {
        CVR_INV_PIN_B,
        CVR_INV_PIN_C,
        CVR_INV_PIN_D,
        CVR_INV_BANDGAP,
        CVR_INV_EXT_REF,
        CVR_INV_OPEN
    } cvr_inv_route_t;

    typedef struct packed {
        logic [`CVR_ADDR_W-1:0] addr;
        logic [`CVR_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cvr_bus_req_t;

endpackage : cvr_pkg

// ===== cvr_ladder_model.sv
module cvr_ladder_model
    import cvr_pkg::*;
#(
    parameter int RAIL_MV = 3300,
    parameter int EXT_HI_MV = 2500,
    parameter int EXT_LO_MV = 500
) (
    input cvr_pkg::cvr_ctrl_t ref_ctrl,
    output logic [15:0] ref_mv,
    output logic [15:0] pin_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Ladder level and output pin.
    // ----------------------------------------
    int lo;
    int span;
    always_comb begin
        lo = ref_ctrl.ladder_supply_select ? EXT_LO_MV : 0;
        span = ref_ctrl.ladder_supply_select ? EXT_HI_MV - EXT_LO_MV : RAIL_MV;
        ref_mv = 16'(lo + int'(ref_ctrl.ladder_level_code) * span / 32);
        if (!ref_ctrl.ladder_power_on) begin
            ref_mv = 16'h0000;
        end
        pin_mv = ref_ctrl.ladder_pin_output_on ? ref_mv : ~ref_mv;
    end
endmodule : cvr_ladder_model

// ===== comparator_reference_control_tb.sv
module comparator_reference_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cvr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    cvr_bus_req_t bus_req = '0;
    logic [15:0] rdata;
    logic [2:0] nsel = 3'h0;
    logic [2:0][1:0] ich = '0;
    cvr_ctrl_t ref_ctrl;
    logic ladder_range;
    cvr_noninv_route_t [2:0] noninv_route;
    cvr_inv_route_t [2:0] inv_route;
    logic [15:0] ref_mv;
    logic [15:0] pin_mv;
    logic [15:0] d;
    logic [4:0] lv [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
    int error_cnt = 0;
    int checks = 0;
    int e;
    always #4 ref_clk = ~ref_clk;
    cvr_ref_ctrl uut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .noninv_input_select(nsel), .inv_input_channel(ich), .ref_ctrl(ref_ctrl),
        .ladder_range(ladder_range), .noninv_route(noninv_route), .inv_route(inv_route));
    cvr_ladder_model far (.ref_ctrl(ref_ctrl), .ref_mv(ref_mv), .pin_mv(pin_mv));
    // ----------------------------------------
    // Access and compare tasks.
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.wdata <= v;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic test_done;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // Tests.
    // ----------------------------------------
    initial begin
        #100000;
        error_cnt++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("ctrl reset", 16'h0000, ref_ctrl);
        rd(16'h0000);
        chk("read reset", 16'h0000, d);
        wr(16'h0000, 16'hffff);
        chk("ctrl all", 16'h07ff, ref_ctrl);
        rd(16'h0000);
        chk("read all", 16'h07ff, d);
        @(posedge ref_clk);
        #1;
        chk("rdata idle", 16'h0000, rdata);
        wr(16'h0010, 16'h0000);
        rd(16'h0010);
        chk("unmapped", 16'h0000, d);
        for (int s = 0; s < 2; s++) begin
            foreach (lv[k]) begin
                wr(16'h0000, 16'h00c0 | 16'(s << 5) | 16'(lv[k]));
                e = s ? 500 + int'(lv[k]) * 2000 / 32 : int'(lv[k]) * 3300 / 32;
                chk("level", 16'(e), ref_mv);
                chk("range", 16'(lv[k][4]), ladder_range);
                chk("pin", ref_mv, pin_mv);
            end
        end
        wr(16'h0000, 16'h0080);
        chk("pin off", 16'h0000, ref_ctrl.ladder_pin_output_on);
        wr(16'h0000, 16'h0000);
        chk("power off", 16'h0000, ref_mv);
        for (int x = 0; x < 2; x++) begin
            wr(16'h0000, 16'(x << 10));
            nsel <= 3'h5;
            @(posedge ref_clk);
            #1;
            chk("noninv set", x ? 16'h0002 : 16'h0001, noninv_route[0]);
            chk("noninv clear", 16'h0000, noninv_route[1]);
        end
        for (int b = 0; b < 4; b++) begin
            wr(16'h0000, 16'(b << 8));
            for (int c = 0; c < 4; c++) begin
                ich <= {3{2'(c)}};
                @(posedge ref_clk);
                #1;
                e = c < 3 ? c : (b == 0 ? 3 : (b == 3 ? 4 : 5));
                chk("inv route", 16'(e), inv_route[2]);
            end
        end
        rd(16'h0004);
        chk("status", 16'h0005, d);
        test_done;
    end
endmodule : comparator_reference_control_tb
